// ==== core/cfgwdt_pkg.sv ====
// Package of constants and types for the configuration bank and watchdog
// Overview of operation
// RULE1 - Switchover bit 7 of clock options byte enables two-speed start-up
// RULE2 - Bit 6 of clock options byte enables the fail-safe clock monitor
// RULE3 - Control select 00 uses oscillator type if default bit set, else internal RC
// RULE4 - Oscillator type: 11 ext+PLL+clkout, 10 ext+clkout, 01 crystal+PLL, 00 crystal
// RULE5 - Four-bit postscale field picks divide ratio two to the field value
// RULE6 - Wait bit 1 disables external bus wait states, 0 enables them
// RULE7 - Width bit 1 selects 16-bit external data bus, 0 selects 8-bit
// RULE8 - Bus field: 11 disabled, 10 12-bit, 01 16-bit, 00 20-bit addresses
// RULE9 - Address shift bit 1 offsets external addresses to zero, else PC value
// RULE10 - Capture routing bit picks port E 6..3 when 1, port H 7..4 when 0
// RULE11 - Capture 2 bit 1 uses port C1, else port E7 or B3 in extended mode
// RULE12 - Implemented bits readable, write-once, read 1 unprogrammed; others read 0
// RULE13 - Eleven-bit read-only part identifier split across both identity registers
// RULE14 - Low five bits of identity register 1 hold the silicon revision
// RULE15 - Watchdog runs from internal RC; enabling watchdog enables the oscillator
// RULE16 - Four millisecond base period feeds 16-bit postscaler selected by field
// RULE17 - Sleep, clear instruction or clock failure clear counter and postscaler
// RULE18 - Watchdog control bit 0 read/write, resets to 0, turns watchdog on/off
// RULE19 - Software enable has no effect while configuration enable is set
// RULE20 - Configuration enable forces watchdog on; otherwise software enable governs
// RULE21 - Configuration bits set to 1 on power-on reset, kept on other resets
// RULE22 - Once programmed in a power cycle, further writes to a bit are ignored
// RULE23 - Postscaler reaching selected count without clear raises a reset request
// RULE24 - Options absent on small package read as 1 and have no effect
package cfgwdt_pkg;
  // Register offsets within the configuration and control space
  localparam logic [21:0] CFGWDT_OFF_WDT_EN_CFG = 22'h30_0000;
  localparam logic [21:0] CFGWDT_OFF_CLOCK = 22'h30_0002;
  localparam logic [21:0] CFGWDT_OFF_POSTSCALE = 22'h30_0003;
  localparam logic [21:0] CFGWDT_OFF_EXT_BUS = 22'h30_0004;
  localparam logic [21:0] CFGWDT_OFF_ROUTING = 22'h30_0005;
  localparam logic [21:0] CFGWDT_OFF_ID_LOW = 22'h3F_FFFE;
  localparam logic [21:0] CFGWDT_OFF_ID_HIGH = 22'h3F_FFFF;
  localparam logic [21:0] CFGWDT_OFF_WDT_CTRL = 22'h00_0FD1;
  localparam logic [21:0] CFGWDT_OFF_RESET_CAUSE = 22'h00_0FD0;
  // Implemented bit masks for each configuration byte
  localparam logic [7:0] CFGWDT_MASK_WDT_EN_CFG = 8'h01;
  localparam logic [7:0] CFGWDT_MASK_CLOCK = 8'hC7;
  localparam logic [7:0] CFGWDT_MASK_POSTSCALE = 8'h0F;
  localparam logic [7:0] CFGWDT_MASK_EXT_BUS = 8'hF8;
  localparam logic [7:0] CFGWDT_MASK_ROUTING = 8'h03;
  // Bits present only on the larger package
  localparam logic [7:0] CFGWDT_LARGE_EXT_BUS = 8'hF8;
  localparam logic [7:0] CFGWDT_LARGE_ROUTING = 8'h02;
  // Field positions
  localparam int CFGWDT_BIT_WDT_EN = 0;
  localparam int CFGWDT_BIT_SWITCHOVER = 7;
  localparam int CFGWDT_BIT_MONITOR = 6;
  localparam int CFGWDT_BIT_DEFAULT_CLK = 2;
  localparam int CFGWDT_BIT_WAIT = 7;
  localparam int CFGWDT_BIT_WIDTH = 6;
  localparam int CFGWDT_BIT_ADDR_SHIFT = 3;
  localparam int CFGWDT_BIT_ENH_ROUTE = 1;
  localparam int CFGWDT_BIT_CAP2_ROUTE = 0;
  localparam int CFGWDT_BIT_SOFT_WDT = 0;
  localparam int CFGWDT_BIT_TIMEOUT_FLAG = 3;
  // Reset values
  localparam logic [7:0] CFGWDT_CFG_RESET = 8'hFF;
  localparam logic [7:0] CFGWDT_CTRL_RESET = 8'h00;
  // Timing: clock period and watchdog base period
  localparam int CFGWDT_CLK_PERIOD_NS = 50;
  localparam int CFGWDT_BASE_PERIOD_US = 4000;
  localparam int CFGWDT_BASE_CYCLES = (CFGWDT_BASE_PERIOD_US * 1000) / CFGWDT_CLK_PERIOD_NS;
  localparam int CFGWDT_POST_W = 16;

  // Oscillator type encodings
  typedef enum logic [1:0] {
    CFGWDT_OSC_CRYSTAL = 2'b00,
    CFGWDT_OSC_CRYSTAL_PLL = 2'b01,
    CFGWDT_OSC_EXT_CLKOUT = 2'b10,
    CFGWDT_OSC_EXT_PLL_CLKOUT = 2'b11
  } cfgwdt_osc_t;

  // Memory bus configurations
  typedef enum logic [1:0] {
    CFGWDT_BUS_ADDR20 = 2'b00,
    CFGWDT_BUS_ADDR16 = 2'b01,
    CFGWDT_BUS_ADDR12 = 2'b10,
    CFGWDT_BUS_OFF = 2'b11
  } cfgwdt_bus_t;

  // Watchdog states
  typedef enum logic [1:0] {
    CFGWDT_ST_OFF = 2'b01,
    CFGWDT_ST_RUN = 2'b10
  } cfgwdt_state_t;

  // Decoded clock options
  typedef struct packed {
    logic startup_switchover_en;
    logic clock_monitor_en;
    logic use_internal_rc;
    logic ext_clock_mode;
    logic crystal_mode;
    logic pll_sw_ctrl;
    logic clock_output;
  } cfgwdt_clock_t;

  // Decoded external bus and routing options
  typedef struct packed {
    logic wait_states_en;
    logic ext_bus_16bit;
    logic ext_bus_enabled;
    logic [4:0] ext_addr_bits;
    logic address_shift_en;
    logic enh_capture_on_port_e;
    logic capture2_on_port_c;
    logic capture2_on_port_b;
  } cfgwdt_bus_cfg_t;

  // Register port request
  typedef struct packed {
    logic [21:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cfgwdt_req_t;
endpackage

// ==== core/cfgwdt_top.sv ====
// Configuration byte bank and watchdog timer
module cfgwdt_top
  import cfgwdt_pkg::*;
#(
  parameter int BASE_CYCLES = CFGWDT_BASE_CYCLES,
  parameter bit LARGE_PACKAGE = 1'b1,
  parameter logic [10:0] PART_ID = 11'h2A5, // Arbitrary value
  parameter logic [4:0] REVISION = 5'h03 // Arbitrary value
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic por_rst,
  // Register port
  input wire cfgwdt_req_t req,
  output logic [7:0] rdata,
  // Core events
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic clock_fail,
  input wire logic ext_mode_active,
  // Decoded configuration
  output cfgwdt_clock_t clock_cfg,
  output cfgwdt_bus_cfg_t bus_cfg,
  output logic [3:0] watchdog_postscale,
  // Watchdog status
  output logic internal_rc_osc_en,
  output logic watchdog_active,
  output logic watchdog_reset_req
);

  localparam logic [7:0] CLK_MASK = CFGWDT_MASK_CLOCK;
  localparam logic [7:0] BUS_AVAIL = LARGE_PACKAGE ? CFGWDT_MASK_EXT_BUS
                                                   : (CFGWDT_MASK_EXT_BUS & ~CFGWDT_LARGE_EXT_BUS);
  localparam logic [7:0] RTE_AVAIL = LARGE_PACKAGE ? CFGWDT_MASK_ROUTING
                                                   : (CFGWDT_MASK_ROUTING & ~CFGWDT_LARGE_ROUTING);
  localparam logic [7:0] BUS_FORCE = CFGWDT_MASK_EXT_BUS & ~BUS_AVAIL;
  localparam logic [7:0] RTE_FORCE = CFGWDT_MASK_ROUTING & ~RTE_AVAIL;
  localparam logic [31:0] BASE_LAST = 32'(BASE_CYCLES - 1);

  // Configuration bytes and their programmed marks
  logic [7:0] cfg_q [5];
  logic [7:0] done_q [5];
  logic [7:0] mask [5];
  logic [21:0] offs [5];
  logic [7:0] cfg_view [5];

  assign mask[0] = CFGWDT_MASK_WDT_EN_CFG;
  assign mask[1] = CLK_MASK;
  assign mask[2] = CFGWDT_MASK_POSTSCALE;
  assign mask[3] = BUS_AVAIL;
  assign mask[4] = RTE_AVAIL;
  assign offs[0] = CFGWDT_OFF_WDT_EN_CFG;
  assign offs[1] = CFGWDT_OFF_CLOCK;
  assign offs[2] = CFGWDT_OFF_POSTSCALE;
  assign offs[3] = CFGWDT_OFF_EXT_BUS;
  assign offs[4] = CFGWDT_OFF_ROUTING;

  // Write-once bytes, set to ones only by power-on reset
  for (genvar i = 0; i < 5; i++)
  begin : g_cfg
    always_ff @(posedge clk)
    begin
      if (por_rst)
      begin
        cfg_q[i] <= CFGWDT_CFG_RESET; // [RULE21]
        done_q[i] <= 8'h00;
      end
      else if (req.wr && req.addr == offs[i])
      begin
        // Only bits never written this power cycle take the new value
        cfg_q[i] <= (cfg_q[i] & (done_q[i] | ~mask[i])) | (req.wdata & mask[i] & ~done_q[i]); // [RULE22]
        done_q[i] <= done_q[i] | mask[i]; // [RULE12] [RULE22]
      end
    end
    // Unimplemented positions read 0, unavailable options read 1
    assign cfg_view[i] = (cfg_q[i] & mask[i]) | ((i == 3) ? BUS_FORCE : (i == 4) ? RTE_FORCE : 8'h00); // [RULE12] [RULE24]
  end

  // Software watchdog enable, cleared by any reset
  logic soft_watchdog_en_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst)
      soft_watchdog_en_q <= CFGWDT_CTRL_RESET[CFGWDT_BIT_SOFT_WDT]; // [RULE18]
    else if (req.wr && req.addr == CFGWDT_OFF_WDT_CTRL)
      soft_watchdog_en_q <= req.wdata[CFGWDT_BIT_SOFT_WDT]; // [RULE18]
  end

  // Effective enable: configuration bit overrides software
  logic cfg_watchdog_en;
  logic watchdog_en;
  assign cfg_watchdog_en = cfg_view[0][CFGWDT_BIT_WDT_EN];
  assign watchdog_en = cfg_watchdog_en | soft_watchdog_en_q; // [RULE19] [RULE20]
  assign watchdog_active = watchdog_en;
  assign internal_rc_osc_en = watchdog_en | clock_cfg.clock_monitor_en; // [RULE15]

  // Decode clock options
  logic [1:0] oscillator_type;
  assign oscillator_type = cfg_view[1][1:0];
  always_comb
  begin
    clock_cfg.startup_switchover_en = cfg_view[1][CFGWDT_BIT_SWITCHOVER]; // [RULE1]
    clock_cfg.clock_monitor_en = cfg_view[1][CFGWDT_BIT_MONITOR]; // [RULE2]
    clock_cfg.use_internal_rc = ~cfg_view[1][CFGWDT_BIT_DEFAULT_CLK]; // [RULE3]
    clock_cfg.ext_clock_mode = 1'b0;
    clock_cfg.crystal_mode = 1'b0;
    clock_cfg.pll_sw_ctrl = 1'b0;
    clock_cfg.clock_output = 1'b0;
    case (oscillator_type) // [RULE4]
      CFGWDT_OSC_EXT_PLL_CLKOUT:
      begin
        clock_cfg.ext_clock_mode = 1'b1;
        clock_cfg.pll_sw_ctrl = 1'b1;
        clock_cfg.clock_output = 1'b1;
      end
      CFGWDT_OSC_EXT_CLKOUT:
      begin
        clock_cfg.ext_clock_mode = 1'b1;
        clock_cfg.clock_output = 1'b1;
      end
      CFGWDT_OSC_CRYSTAL_PLL:
      begin
        clock_cfg.crystal_mode = 1'b1;
        clock_cfg.pll_sw_ctrl = 1'b1;
      end
      default:
        clock_cfg.crystal_mode = 1'b1;
    endcase
  end

  // Decode external bus and pin routing options
  logic [1:0] memory_bus_config;
  assign memory_bus_config = cfg_view[3][5:4];
  always_comb
  begin
    bus_cfg.wait_states_en = ~cfg_view[3][CFGWDT_BIT_WAIT]; // [RULE6]
    bus_cfg.ext_bus_16bit = cfg_view[3][CFGWDT_BIT_WIDTH]; // [RULE7]
    bus_cfg.address_shift_en = cfg_view[3][CFGWDT_BIT_ADDR_SHIFT]; // [RULE9]
    bus_cfg.enh_capture_on_port_e = cfg_view[4][CFGWDT_BIT_ENH_ROUTE]; // [RULE10]
    bus_cfg.capture2_on_port_c = cfg_view[4][CFGWDT_BIT_CAP2_ROUTE]; // [RULE11]
    bus_cfg.capture2_on_port_b = ~cfg_view[4][CFGWDT_BIT_CAP2_ROUTE] & ext_mode_active; // [RULE11]
    case (memory_bus_config) // [RULE8]
      CFGWDT_BUS_ADDR20:
      begin
        bus_cfg.ext_bus_enabled = 1'b1;
        bus_cfg.ext_addr_bits = 5'd20;
      end
      CFGWDT_BUS_ADDR16:
      begin
        bus_cfg.ext_bus_enabled = 1'b1;
        bus_cfg.ext_addr_bits = 5'd16;
      end
      CFGWDT_BUS_ADDR12:
      begin
        bus_cfg.ext_bus_enabled = 1'b1;
        bus_cfg.ext_addr_bits = 5'd12;
      end
      default:
      begin
        bus_cfg.ext_bus_enabled = 1'b0;
        bus_cfg.ext_addr_bits = 5'd0;
      end
    endcase
  end

  assign watchdog_postscale = cfg_view[2][3:0];

  // Watchdog state
  cfgwdt_state_t state_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst)
      state_q <= CFGWDT_ST_OFF;
    else
      case (state_q)
        CFGWDT_ST_OFF: if (watchdog_en) state_q <= CFGWDT_ST_RUN;
        CFGWDT_ST_RUN: if (!watchdog_en) state_q <= CFGWDT_ST_OFF;
        default: state_q <= CFGWDT_ST_OFF;
      endcase
  end

  logic wdt_clear;
  assign wdt_clear = sleep_instr | watchdog_clear_instr | clock_fail; // [RULE17]

  // Base period divider makes a one-cycle tick
  logic [31:0] base_q;
  logic base_tick;
  // Gated by the live enable as well, so no tick lands in the cycle after a disable
  assign base_tick = (state_q == CFGWDT_ST_RUN) && watchdog_en && (base_q == BASE_LAST); // [RULE16] [RULE20]
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst || wdt_clear || state_q != CFGWDT_ST_RUN)
      base_q <= 32'h0000_0000; // [RULE17]
    else if (base_tick)
      base_q <= 32'h0000_0000;
    else
      base_q <= base_q + 32'h0000_0001;
  end

  // Postscaler and time-out selection
  logic [CFGWDT_POST_W-1:0] post_q;
  logic [CFGWDT_POST_W:0] post_next;
  logic timeout;
  assign post_next = {1'b0, post_q} + 17'h0_0001;
  // Selected stage carries out after 2**field ticks
  assign timeout = base_tick && (watchdog_postscale == 4'h0 ||
                   post_next[watchdog_postscale] && post_q[watchdog_postscale] == 1'b0 &&
                   (post_q & ((16'h0001 << watchdog_postscale) - 16'h0001)) ==
                   ((16'h0001 << watchdog_postscale) - 16'h0001)); // [RULE5] [RULE16]
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst || wdt_clear || state_q != CFGWDT_ST_RUN || timeout)
      post_q <= 16'h0000; // [RULE17]
    else if (base_tick)
      post_q <= post_next[CFGWDT_POST_W-1:0];
  end

  // Reset request pulse and sticky time-out flag
  logic timeout_flag_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst)
      watchdog_reset_req <= 1'b0;
    else
      watchdog_reset_req <= timeout && !wdt_clear; // [RULE23]
  end
  always_ff @(posedge clk)
  begin
    if (por_rst)
      timeout_flag_q <= 1'b0;
    else if (watchdog_reset_req)
      timeout_flag_q <= 1'b1;
    else if (req.wr && req.addr == CFGWDT_OFF_RESET_CAUSE)
      timeout_flag_q <= req.wdata[CFGWDT_BIT_TIMEOUT_FLAG];
  end

  // Read data, one cycle after the strobe
  logic [7:0] rdata_d;
  always_comb
  begin
    rdata_d = 8'h00;
    for (int k = 0; k < 5; k++)
      if (req.addr == offs[k]) rdata_d = cfg_view[k]; // [RULE12]
    if (req.addr == CFGWDT_OFF_ID_LOW) rdata_d = {PART_ID[2:0], REVISION}; // [RULE13] [RULE14]
    if (req.addr == CFGWDT_OFF_ID_HIGH) rdata_d = PART_ID[10:3]; // [RULE13]
    if (req.addr == CFGWDT_OFF_WDT_CTRL) rdata_d = {7'h00, soft_watchdog_en_q}; // [RULE18]
    if (req.addr == CFGWDT_OFF_RESET_CAUSE) rdata_d = {4'h0, timeout_flag_q, 3'h0};
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst)
      rdata <= 8'h00;
    else if (req.rd)
      rdata <= rdata_d;
    else
      rdata <= 8'h00;
  end
endmodule

// ==== tb/cfgwdt_chk.sv ====
// Port checker for the configuration bank and watchdog
module cfgwdt_chk
  import cfgwdt_pkg::*;
#(
  parameter int BASE_CYCLES = 4
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic por_rst,
  // Register port
  input wire cfgwdt_req_t req,
  input wire logic [7:0] rdata,
  // Core events
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic clock_fail,
  input wire logic ext_mode_active,
  // Decoded configuration
  input wire cfgwdt_clock_t clock_cfg,
  input wire cfgwdt_bus_cfg_t bus_cfg,
  input wire logic [3:0] watchdog_postscale,
  // Watchdog status
  input wire logic internal_rc_osc_en,
  input wire logic watchdog_active,
  input wire logic watchdog_reset_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || por_rst);

  // Cycles since the last clear event, saturating
  int since_clear_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst || sleep_instr || watchdog_clear_instr || clock_fail)
      since_clear_q <= 0;
    else if (since_clear_q < 100000)
      since_clear_q <= since_clear_q + 1;
  end

  // Read data only follows a read strobe
  sequence s_no_read;
    !req.rd ##1 1'b1;
  endsequence
  sequence s_off_run;
    (!watchdog_active) [*3];
  endsequence

  a_rdata_idle_zero: assert property (s_no_read |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_req_one_pulse: assert property (watchdog_reset_req |=> !watchdog_reset_req)
    else $error("time-out pulse too long");
  a_req_when_on: assert property (watchdog_reset_req |-> $past(watchdog_active))
    else $error("time-out while watchdog off");
  a_off_no_req: assert property (s_off_run |-> !watchdog_reset_req)
    else $error("time-out from idle watchdog");
  a_clear_holds: assert property (watchdog_reset_req |-> since_clear_q >= BASE_CYCLES - 1)
    else $error("time-out too soon after clear");
  a_rc_with_wdt: assert property (watchdog_active |-> internal_rc_osc_en)
    else $error("watchdog on without RC oscillator");
  a_rc_with_mon: assert property (clock_cfg.clock_monitor_en |-> internal_rc_osc_en)
    else $error("monitor on without RC oscillator");
  a_osc_decode: assert property (clock_cfg.clock_output == clock_cfg.ext_clock_mode &&
    clock_cfg.crystal_mode == !clock_cfg.ext_clock_mode)
    else $error("oscillator type decode wrong");
  a_bus_addr: assert property (bus_cfg.ext_bus_enabled == (bus_cfg.ext_addr_bits != 5'd0))
    else $error("bus enable and address width disagree");
  a_cap2_route: assert property (bus_cfg.capture2_on_port_b |->
    ext_mode_active && !bus_cfg.capture2_on_port_c)
    else $error("capture 2 routing wrong");
  // Power-on reset restores the field to ones, which is a legal change too
  a_ps_stable: assert property (!$stable(watchdog_postscale) |->
    $past(por_rst) || $past(req.wr && req.addr == CFGWDT_OFF_POSTSCALE))
    else $error("postscale changed without write");
endmodule

// ==== tb/cfgwdt_top_tb.sv ====
// Self-checking bench for the configuration bank and watchdog
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module cfgwdt_top_tb
  import cfgwdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = 4;
  localparam logic [10:0] PID = 11'h35A; // Arbitrary value
  localparam logic [4:0] SILICON_REVISION = 5'h0B; // Arbitrary value
  typedef struct { logic [21:0] a; logic [7:0] w; logic [7:0] r0; logic [7:0] r1; } cfgwdt_row_t;
  logic clk = 0, sys_rst = 1, por_rst = 1, sleep_instr = 0, watchdog_clear_instr = 0, clock_fail = 0;
  logic ext_mode_active = 0;
  cfgwdt_req_t req = '0;
  logic [7:0] rdata, d;
  cfgwdt_clock_t clock_cfg;
  cfgwdt_bus_cfg_t bus_cfg;
  logic [3:0] watchdog_postscale;
  logic internal_rc_osc_en, watchdog_active, watchdog_reset_req;
  int errors = 0, tests_run = 0, cycles = 0, n;
  cfgwdt_row_t rows [8] = '{
    '{CFGWDT_OFF_WDT_EN_CFG, 8'h00, 8'h01, 8'h00}, '{CFGWDT_OFF_CLOCK, 8'h42, 8'hC7, 8'h42},
    '{CFGWDT_OFF_POSTSCALE, 8'hF0, 8'h0F, 8'h00}, '{CFGWDT_OFF_EXT_BUS, 8'h57, 8'hF8, 8'h50},
    '{CFGWDT_OFF_ROUTING, 8'hFE, 8'h03, 8'h02}, '{CFGWDT_OFF_ID_LOW, 8'h00, {PID[2:0], SILICON_REVISION}, {PID[2:0], SILICON_REVISION}},
    '{CFGWDT_OFF_ID_HIGH, 8'h00, PID[10:3], PID[10:3]}, '{22'h30_0006, 8'hFF, 8'h00, 8'h00}};

  cfgwdt_top #(.BASE_CYCLES(BASE), .LARGE_PACKAGE(1'b1), .PART_ID(PID), .REVISION(SILICON_REVISION)) u_cfgwdt_top (
    .clk, .sys_rst, .por_rst, .req, .rdata, .sleep_instr, .watchdog_clear_instr, .clock_fail,
    .ext_mode_active, .clock_cfg, .bus_cfg, .watchdog_postscale, .internal_rc_osc_en,
    .watchdog_active, .watchdog_reset_req);

  // Free-running clock
  always #25 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [21:0] a, input logic [7:0] w);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= w;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [21:0] a, output logic [7:0] v);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Cycles between two successive time-out pulses
  task automatic req_gap(output int p);
    int k;
    k = 0;
    while (watchdog_reset_req !== 1'b1 && k < 300)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    p = 0;
    do
    begin
      @(posedge clk);
      #1;
      p++;
    end
    while (watchdog_reset_req !== 1'b1 && p < 300);
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("active_after_por", 1'b1, watchdog_active)
    foreach (rows[i])
    begin
      rd(rows[i].a, d);
      `CHK("reset_read", rows[i].r0, d)
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK("first_write", rows[i].r1, d)
      wr(rows[i].a, ~rows[i].w);
      rd(rows[i].a, d);
      `CHK("second_write", rows[i].r1, d)
    end
    ext_mode_active <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("clock_cfg", 7'b0111001, clock_cfg)
    `CHK("bus_cfg", {3'b111, 5'd16, 4'b0101}, bus_cfg)
    `CHK("postscale", 4'h0, watchdog_postscale)
    `CHK("wdt_off", 1'b0, watchdog_active)
    wr(CFGWDT_OFF_WDT_CTRL, 8'h01);
    rd(CFGWDT_OFF_WDT_CTRL, d);
    `CHK("ctrl_read", 8'h01, d)
    `CHK("soft_on", 1'b1, watchdog_active)
    req_gap(n);
    `CHK("base_period", BASE, n)
    rd(CFGWDT_OFF_RESET_CAUSE, d);
    `CHK("timeout_flag", 1'b1, d[CFGWDT_BIT_TIMEOUT_FLAG])
    // Each clear source holds off the time-out
    for (int s = 0; s < 3; s++)
    begin
      req_gap(n);
      n = 0;
      repeat (8)
      begin
        @(posedge clk);
        sleep_instr <= (s == 0);
        watchdog_clear_instr <= (s == 1);
        clock_fail <= (s == 2);
        @(posedge clk);
        {sleep_instr, watchdog_clear_instr, clock_fail} <= 3'b000;
        #1;
        n += int'(watchdog_reset_req);
      end
      `CHK("cleared", 0, n)
    end
    wr(CFGWDT_OFF_WDT_CTRL, 8'h00);
    @(posedge clk);
    #1;
    `CHK("soft_off", 1'b0, watchdog_active)
    `CHK("rc_for_monitor", 1'b1, internal_rc_osc_en)
    wr(CFGWDT_OFF_WDT_CTRL, 8'h01);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(CFGWDT_OFF_CLOCK, d);
    `CHK("kept_on_reset", 8'h42, d)
    rd(CFGWDT_OFF_WDT_CTRL, d);
    `CHK("ctrl_reset", 8'h00, d)
    @(posedge clk);
    por_rst <= 1'b1;
    @(posedge clk);
    por_rst <= 1'b0;
    rd(CFGWDT_OFF_CLOCK, d);
    `CHK("por_restore", 8'hC7, d)
    wr(CFGWDT_OFF_CLOCK, 8'h80);
    rd(CFGWDT_OFF_CLOCK, d);
    `CHK("writable_again", 8'h80, d)
    wr(CFGWDT_OFF_WDT_CTRL, 8'h00);
    @(posedge clk);
    #1;
    `CHK("cfg_forces_on", 1'b1, watchdog_active)
    wr(CFGWDT_OFF_POSTSCALE, 8'h02);
    @(posedge clk);
    watchdog_clear_instr <= 1'b1;
    @(posedge clk);
    watchdog_clear_instr <= 1'b0;
    req_gap(n);
    `CHK("scaled_period", BASE * 4, n)
    `CHK("postscale_set", 4'h2, watchdog_postscale)
    stop_test();
  end
endmodule

bind cfgwdt_top cfgwdt_chk #(.BASE_CYCLES(BASE_CYCLES)) u_cfgwdt_chk (
  .clk, .sys_rst, .por_rst, .req, .rdata, .sleep_instr, .watchdog_clear_instr, .clock_fail,
  .ext_mode_active, .clock_cfg, .bus_cfg, .watchdog_postscale, .internal_rc_osc_en,
  .watchdog_active, .watchdog_reset_req);
